// ===== hdl/xamr_router.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - mode 00 sends every move on-chip
// - internal-only addresses wrap modulo 8 kB
// - 8-bit address is page byte plus pointer
// - 16-bit move uses full data pointer
// - mode 01 splits at xram size boundary
// - 8-bit split decision uses page byte
// - no-bank off-chip 8-bit leaves upper undriven
// - 16-bit split decides by pointer, drives all
// - mode 10 splits at xram size boundary
// - bank-select 8-bit off-chip drives all sixteen
// - mode 11 sends every move off-chip
// - external-only 8-bit ignores page, upper undriven
// - external-only 16-bit drives all sixteen lines
module xamr_router (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// configuration from the core
	input wire logic [1:0] memory_mode_config,
	input wire logic [7:0] xram_page_select,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] indirect_pointer_zero,
	input wire logic [7:0] indirect_pointer_one,
	input wire logic [7:0] port_latch_hi,
	// external_data_move request from the core
	input wire logic move_req,
	input wire logic move_wide,
	input wire logic move_sel_one,
	input wire logic move_write,
	input wire logic [7:0] move_wdata,
	output logic move_done,
	output logic [7:0] move_rdata,
	// off-chip bus
	output logic [15:0] ext_addr,
	output logic [7:0] ext_addr_hi_oe_b,
	output logic [7:0] ext_addr_lo_oe_b,
	output logic ext_rd_b,
	output logic ext_wr_b,
	output logic [7:0] ext_dq_out,
	output logic [7:0] ext_dq_oe_b,
	input wire logic [7:0] ext_dq_in
);
	xamr_pkg::xamr_state_t state_r;
	logic [15:0] eff_addr;
	logic off_chip;
	logic drive_hi;
	logic [7:0] ptr_lo;
	logic [7:0] xram_mem [0:xamr_pkg::XAMR_XRAM_BYTES-1];
	logic [xamr_pkg::XAMR_XRAM_AW-1:0] int_addr;
	logic [15:0] addr_r;
	logic drive_hi_r;
	logic write_r;
	logic [7:0] wdata_r;
	logic [7:0] dq_s1_r, dq_s2_r, dq_s3_r;
	logic [7:0] rdata_r;
	logic done_r;

	assign ptr_lo = move_sel_one ? indirect_pointer_one : indirect_pointer_zero;

	xamr_addr_decode u_dec (
		.mode(memory_mode_config),
		.page_sel(xram_page_select),
		.wide(move_wide),
		.ptr_lo(ptr_lo),
		.data_pointer(data_pointer),
		.eff_addr(eff_addr),
		.off_chip(off_chip),
		.drive_hi(drive_hi)
	);

	// dropping the upper bits gives the 8 kB wrap for free
	assign int_addr = eff_addr[xamr_pkg::XAMR_XRAM_AW-1:0];

	// sequence: one cycle on-chip, four cycles off-chip so read data settles through the synchroniser
	logic [1:0] ext_cnt_r;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= xamr_pkg::XAMR_ST_IDLE;
			ext_cnt_r <= 2'h0;
		end else begin
			case (state_r)
				xamr_pkg::XAMR_ST_IDLE: begin
					ext_cnt_r <= 2'h0;
					if (move_req) begin
						state_r <= off_chip ? xamr_pkg::XAMR_ST_EXT : xamr_pkg::XAMR_ST_INT;
					end
				end
				xamr_pkg::XAMR_ST_INT: begin
					state_r <= xamr_pkg::XAMR_ST_IDLE;
				end
				xamr_pkg::XAMR_ST_EXT: begin
					ext_cnt_r <= ext_cnt_r + 2'h1;
					if (ext_cnt_r == xamr_pkg::XAMR_EXT_LAST) begin
						state_r <= xamr_pkg::XAMR_ST_IDLE;
					end
				end
				default: begin
					state_r <= xamr_pkg::XAMR_ST_IDLE;
				end
			endcase
		end
	end

	// capture the request when it is taken
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			addr_r <= xamr_pkg::XAMR_ADDR_RST;
			drive_hi_r <= 1'b0;
			write_r <= 1'b0;
			wdata_r <= xamr_pkg::XAMR_DATA_RST;
		end else if (state_r == xamr_pkg::XAMR_ST_IDLE && move_req) begin
			addr_r <= eff_addr;
			drive_hi_r <= drive_hi;
			write_r <= move_write;
			wdata_r <= move_wdata;
		end
	end

	// on-chip xram, no reset on the array itself
	always_ff @(posedge mclk) begin
		if (state_r == xamr_pkg::XAMR_ST_IDLE && move_req && !off_chip && move_write) begin
			xram_mem[int_addr] <= move_wdata;
		end
	end

	// read data sync from pins; only stages two and three are compared
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dq_s1_r <= xamr_pkg::XAMR_DATA_RST;
			dq_s2_r <= xamr_pkg::XAMR_DATA_RST;
			dq_s3_r <= xamr_pkg::XAMR_DATA_RST;
		end else begin
			dq_s1_r <= ext_dq_in;
			dq_s2_r <= dq_s1_r;
			dq_s3_r <= dq_s2_r;
		end
	end

	// read data and completion
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= xamr_pkg::XAMR_DATA_RST;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (state_r == xamr_pkg::XAMR_ST_IDLE && move_req && !off_chip) begin
				rdata_r <= xram_mem[int_addr];
				done_r <= 1'b1;
			end else if (state_r == xamr_pkg::XAMR_ST_EXT && ext_cnt_r == xamr_pkg::XAMR_EXT_LAST) begin
				if (!write_r && dq_s2_r == dq_s3_r) begin
					rdata_r <= dq_s3_r;
				end
				done_r <= 1'b1;
			end
		end
	end
	assign move_done = done_r;
	assign move_rdata = rdata_r;

	// off-chip bus pins; upper byte falls back to port latch when not driven
	logic ext_act;
	assign ext_act = state_r == xamr_pkg::XAMR_ST_EXT;
	assign ext_addr = {(ext_act && drive_hi_r) ? addr_r[15:8] : port_latch_hi, addr_r[7:0]};
	assign ext_addr_hi_oe_b = {8{!(ext_act && drive_hi_r)}};
	assign ext_addr_lo_oe_b = {8{!ext_act}};
	assign ext_rd_b = !(ext_act && !write_r);
	assign ext_wr_b = !(ext_act && write_r);
	assign ext_dq_out = wdata_r;
	assign ext_dq_oe_b = {8{!(ext_act && write_r)}};
endmodule
`default_nettype wire

// ===== common/xamr_pkg.sv
package xamr_pkg;
	// memory-mode field encodings
	typedef enum logic [1:0] {
		XAMR_MODE_INT_ONLY = 2'h0,
		XAMR_MODE_SPLIT_NOBANK = 2'h1,
		XAMR_MODE_SPLIT_BANK = 2'h2,
		XAMR_MODE_EXT_ONLY = 2'h3
	} xamr_mode_t;
	// on-chip xram size: 8 kB
	localparam int XAMR_XRAM_BYTES = 8192;
	localparam int XAMR_XRAM_AW = 13;
	localparam logic [15:0] XAMR_XRAM_LIMIT = 16'h2000;
	// reset values
	localparam logic [15:0] XAMR_ADDR_RST = 16'h0000;
	localparam logic [7:0] XAMR_DATA_RST = 8'h00;
	// off-chip strobe length: counter value of the last of four cycles
	localparam logic [1:0] XAMR_EXT_LAST = 2'h3;
	// controller states
	typedef enum logic [2:0] {
		XAMR_ST_IDLE = 3'h1,
		XAMR_ST_INT = 3'h2,
		XAMR_ST_EXT = 3'h4
	} xamr_state_t;
endpackage

// ===== hdl/xamr_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
// combinational address formation and on/off-chip decision
module xamr_addr_decode (
	// configuration
	input wire logic [1:0] mode,
	input wire logic [7:0] page_sel,
	// request
	input wire logic wide,
	input wire logic [7:0] ptr_lo,
	input wire logic [15:0] data_pointer,
	// result
	output logic [15:0] eff_addr,
	output logic off_chip,
	output logic drive_hi
);
	logic [15:0] addr8;
	logic below;
	// 8-bit form: high byte from page select, low from pointer
	assign addr8 = {page_sel, ptr_lo};
	// 16-bit form uses the data pointer whole
	assign eff_addr = wide ? data_pointer : addr8;
	assign below = eff_addr < xamr_pkg::XAMR_XRAM_LIMIT;
	// pick the target per mode
	always_comb begin
		off_chip = 1'b0;
		drive_hi = 1'b0;
		case (mode)
			xamr_pkg::XAMR_MODE_INT_ONLY: begin
				off_chip = 1'b0;
				drive_hi = 1'b0;
			end
			xamr_pkg::XAMR_MODE_SPLIT_NOBANK: begin
				off_chip = !below;
				drive_hi = wide;
			end
			xamr_pkg::XAMR_MODE_SPLIT_BANK: begin
				off_chip = !below;
				drive_hi = 1'b1;
			end
			xamr_pkg::XAMR_MODE_EXT_ONLY: begin
				off_chip = 1'b1;
				drive_hi = wide;
			end
			default: begin
				off_chip = 1'b0;
				drive_hi = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== tb/xamr_router_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module xamr_router_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// core side
	input wire logic [1:0] memory_mode_config,
	input wire logic [7:0] xram_page_select,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] port_latch_hi,
	input wire logic move_req,
	input wire logic move_wide,
	input wire logic move_write,
	input wire logic move_done,
	// off-chip bus
	input wire logic [15:0] ext_addr,
	input wire logic [7:0] ext_addr_hi_oe_b,
	input wire logic [7:0] ext_addr_lo_oe_b,
	input wire logic ext_rd_b,
	input wire logic ext_wr_b,
	input wire logic [7:0] ext_dq_oe_b
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// four strobed cycles, then the answer
	sequence ext_cycle;
		(ext_addr_lo_oe_b == 8'h00 && !(ext_rd_b && ext_wr_b))[*4] ##1 move_done;
	endsequence
	// upper lanes released, pins follow the port latch
	sequence upper_free;
		(ext_addr_hi_oe_b == 8'hff && ext_addr[15:8] == port_latch_hi)[*4];
	endsequence
	chk_int_only: assert property (move_req && memory_mode_config == 2'h0 |=> move_done && ext_rd_b && ext_wr_b)
		else $error("int move late");
	chk_ext_only: assert property (move_req && memory_mode_config == 2'h3 |=> ext_cycle)
		else $error("ext cycle wrong");
	chk_ext8_upper: assert property (move_req && memory_mode_config == 2'h3 && !move_wide |=> upper_free)
		else $error("ext upper driven");
	chk_nobank_upper: assert property (move_req && memory_mode_config == 2'h1 && !move_wide
		&& xram_page_select >= 8'h20 |=> upper_free)
		else $error("nobank upper driven");
	chk_bank_upper: assert property (move_req && memory_mode_config == 2'h2 && !move_wide && xram_page_select >= 8'h20
		|=> ext_addr_hi_oe_b == 8'h00 && ext_addr[15:8] == $past(xram_page_select))
		else $error("bank upper wrong");
	chk_wide_addr: assert property (move_req && move_wide && memory_mode_config != 2'h0 && (data_pointer >= 16'h2000
		|| memory_mode_config == 2'h3) |=> ext_addr == $past(data_pointer) && ext_addr_hi_oe_b == 8'h00)
		else $error("wide address wrong");
	chk_split_low: assert property (move_req && ^memory_mode_config && move_wide && data_pointer < 16'h2000
		|=> move_done)
		else $error("split low not on-chip");
	chk_dq_drive: assert property (move_req && move_write && memory_mode_config == 2'h3
		|=> (ext_dq_oe_b == 8'h00 && !ext_wr_b)[*4])
		else $error("write data not driven");
endmodule
bind xamr_router xamr_router_assertions chk (.*);
`default_nettype wire

// ===== tb/xamr_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module xamr_ext_mem (
	// off-chip bus
	input wire logic mclk,
	input wire logic [15:0] ext_addr,
	input wire logic ext_rd_b,
	input wire logic ext_wr_b,
	input wire logic [7:0] ext_dq_out,
	output logic [7:0] ext_dq_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r = 8'h00;
	// store on write strobe, remember the last byte read
	always @(posedge mclk) begin
		if (!ext_wr_b)
			mem[ext_addr] <= ext_dq_out;
		if (!ext_rd_b)
			last_r <= mem[ext_addr];
	end
	// released bus shows the inverse so stale data cannot pass
	assign ext_dq_in = ext_rd_b ? ~last_r : mem[ext_addr];
endmodule
`default_nettype wire

// ===== tb/xamr_router_bench.sv
`timescale 1ns/1ps
`default_nettype none
module xamr_router_bench;
	logic mclk = 1'b0, rst_b = 1'b0, move_req = 1'b0, move_wide = 1'b0, move_sel_one = 1'b0, move_write = 1'b0;
	logic [1:0] memory_mode_config = 2'h0;
	logic [7:0] xram_page_select = 8'h00, indirect_pointer_zero = 8'h00, indirect_pointer_one = 8'h00;
	logic [7:0] port_latch_hi = 8'h00, move_wdata = 8'h00, move_rdata, ext_dq_out, ext_dq_oe_b, ext_dq_in;
	logic [7:0] ext_addr_hi_oe_b, ext_addr_lo_oe_b, pages [6] = '{8'h00, 8'h1f, 8'h20, 8'h40, 8'h60, 8'hff};
	logic [15:0] data_pointer = 16'h0000, ext_addr;
	logic move_done, ext_rd_b, ext_wr_b;
	logic [7:0] imem [int], emem [int];
	int seed = 32'h20182279, num_errors = 0, total_checks = 0;
	xamr_router dut (.*);
	xamr_ext_mem far (.*);
	always #5 mclk = ~mclk;
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] pick();
		return pages[$unsigned($random(seed)) % 6];
	endfunction
	// one random move, expectations from the mode rules
	task automatic do_move();
		int lat, a, ea;
		logic off;
		logic [7:0] ptr;
		@(negedge mclk);
		{memory_mode_config, move_wide, move_sel_one, move_write} = 5'($random(seed));
		xram_page_select = pick();
		port_latch_hi = pick();
		data_pointer = {pick(), 6'h00, 2'($random(seed))};
		indirect_pointer_zero = 8'($unsigned($random(seed)) % 4);
		indirect_pointer_one = 8'($unsigned($random(seed)) % 4);
		move_wdata = 8'($random(seed));
		move_req = 1'b1;
		ptr = move_sel_one ? indirect_pointer_one : indirect_pointer_zero;
		a = move_wide ? data_pointer : {xram_page_select, ptr};
		off = memory_mode_config == 2'h3 || (memory_mode_config != 2'h0 && a >= 'h2000);
		ea = (!move_wide && memory_mode_config != 2'h2) ? {port_latch_hi, ptr} : a;
		@(negedge mclk);
		move_req = 1'b0;
		lat = 1;
		while (move_done !== 1'b1 && lat < 20) begin
			@(negedge mclk);
			lat++;
		end
		chk(8'(lat), off ? 8'h05 : 8'h01);
		if (lat >= 20)
			test_done();
		if (move_write && off)
			emem[ea] = move_wdata;
		else if (move_write)
			imem[a % 8192] = move_wdata;
		else if (off ? emem.exists(ea) : imem.exists(a % 8192))
			chk(move_rdata, off ? emem[ea] : imem[a % 8192]);
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		repeat (400) do_move();
		test_done();
	end
endmodule
`default_nettype wire
